// [design/pcm_port_c_upper_pin_mux.sv]
// port c pin mux: apb register file, pin drive selection, peripheral input routing
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.svh"

module pcm_port_c_upper_pin_mux
    import pcm_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // port c pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    // synchronous serial unit side
    input wire pcm_ssu_mode_t ssu_mode_in,
    input wire logic ssu_smbus_levels_in,
    input wire logic spi_sck_drive_in,
    input wire logic spi_sdo_drive_in,
    input wire logic i2c_scl_drive_in,
    input wire logic i2c_sda_drive_in,
    output logic spi_sck_sense_out,
    output logic spi_sdi_sense_out,
    output logic i2c_scl_sense_out,
    output logic i2c_sda_sense_out,
    output logic [1:0] pin_smbus_levels_out,
    // usart side
    input wire pcm_usart_mode_t usart_mode_in,
    input wire logic usart_tx_drive_in,
    input wire logic usart_sync_clock_drive_in,
    input wire logic usart_sync_data_drive_in,
    input wire logic usart_sync_data_sending_in,
    output logic usart_rx_sense_out,
    output logic usart_sync_clock_sense_out,
    output logic usart_sync_data_sense_out,
    // capture/compare two side
    input wire logic cc2_pin_select_in,
    input wire logic cc2_drive_in,
    input wire logic cc2_drive_en_in,
    input wire logic port_b_bit3_in,
    output logic cc2_capture_out,
    output logic port_b_bit3_cc2_out,
    output logic port_b_bit3_cc2_en_out
);

    // =====================================================================
    // apb decode
    // =====================================================================

    logic [7:0] output_latch_c_r;
    logic [7:0] pin_direction_c_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic setup_phase;
    logic wr_access;
    logic hit_pin_state;
    logic hit_out_latch;
    logic hit_pin_dir;
    logic addr_mapped;
    logic [2:0] reg_sel;

    // map an apb offset to one of the three registers
    function automatic logic [2:0] decode_offset(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (addr)
            `PCM_OFF_PIN_STATE: sel = 3'h1;
            `PCM_OFF_OUT_LATCH: sel = 3'h2;
            `PCM_OFF_PIN_DIR: sel = 3'h4;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction

    // decoded strobes
    assign setup_phase = psel_in & ~penable_in;
    assign wr_access = psel_in & penable_in & pwrite_in;
    assign reg_sel = decode_offset(paddr_in);
    assign hit_pin_state = reg_sel[0];
    assign hit_out_latch = reg_sel[1];
    assign hit_pin_dir = reg_sel[2];
    assign addr_mapped = |reg_sel;

    // zero wait states: read data is already captured during setup
    assign pready_out = 1'b1;
    assign prdata_out = prdata_r;
    assign pslverr_out = pslverr_r & psel_in & penable_in;

    // =====================================================================
    // registers
    // =====================================================================

    // output latch: writes to either port register land in the latch
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            output_latch_c_r <= `PCM_LATCH_RESET;
        end
        else if (wr_access && (hit_out_latch || hit_pin_state))
        begin
            output_latch_c_r <= pwdata_in[7:0];
        end
    end

    // direction register, all inputs after reset
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            pin_direction_c_r <= `PCM_DIR_RESET;
        end
        else if (wr_access && hit_pin_dir)
        begin
            pin_direction_c_r <= pwdata_in[7:0];
        end
    end

    // read data captured in setup; latch and direction read stored values, pin state reads the pin levels
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup_phase)
        begin
            pslverr_r <= ~addr_mapped;
            prdata_r <= 32'h0000_0000;
            if (hit_pin_state)
            begin
                prdata_r <= {24'h00_0000, pin_in};
            end
            else if (hit_out_latch)
            begin
                prdata_r <= {24'h00_0000, output_latch_c_r};
            end
            else if (hit_pin_dir)
            begin
                prdata_r <= {24'h00_0000, pin_direction_c_r};
            end
        end
    end

    // =====================================================================
    // pin drive selection
    // =====================================================================

    pcm_drive_t [7:0] drive_nxt;
    pcm_drive_t [7:0] port_drive;
    logic ssu_spi;
    logic ssu_i2c;

    // plain port drive from direction bit and latch
    function automatic pcm_drive_t port_default(input logic dir, input logic lat);
        pcm_drive_t d;
        d.oe = ~dir;
        d.val = lat;
        return d;
    endfunction

    // one default drive per pin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_port
            assign port_drive[gi] =
                port_default(pin_direction_c_r[gi], output_latch_c_r[gi]);
        end
    endgenerate

    assign ssu_spi = (ssu_mode_in == PCM_SSU_SPI);
    assign ssu_i2c = (ssu_mode_in == PCM_SSU_I2C);

    // peripherals claim pins ahead of port data
    always_comb
    begin
        drive_nxt = port_drive;
        // bit 1: capture/compare two output, only when it lives here
        if (cc2_pin_select_in && cc2_drive_en_in && !pin_direction_c_r[`PCM_BIT_CC2])
        begin
            drive_nxt[`PCM_BIT_CC2] = '{oe: 1'b1, val: cc2_drive_in};
        end
        // bit 3: spi clock master, or i2c clock open drain
        if (ssu_spi && !pin_direction_c_r[`PCM_BIT_SCK])
        begin
            drive_nxt[`PCM_BIT_SCK] = '{oe: 1'b1, val: spi_sck_drive_in};
        end
        else if (ssu_i2c)
        begin
            // open drain: pull low only, direction bit ignored
            drive_nxt[`PCM_BIT_SCK] = '{oe: ~i2c_scl_drive_in, val: 1'b0};
        end
        // bit 4: i2c data open drain; spi leaves it to the port as input
        if (ssu_i2c)
        begin
            drive_nxt[`PCM_BIT_SDI] = '{oe: ~i2c_sda_drive_in, val: 1'b0};
        end
        // bit 5: spi data out
        if (ssu_spi && !pin_direction_c_r[`PCM_BIT_SDO])
        begin
            drive_nxt[`PCM_BIT_SDO] = '{oe: 1'b1, val: spi_sdo_drive_in};
        end
        // bit 6 and bit 7: usart
        unique case (usart_mode_in)
            PCM_USART_ASYNC:
            begin
                // transmit drives even if software left the pin an input
                drive_nxt[`PCM_BIT_TX] = '{oe: 1'b1, val: usart_tx_drive_in};
            end
            PCM_USART_SYNC_MASTER:
            begin
                drive_nxt[`PCM_BIT_TX] = '{oe: 1'b1, val: usart_sync_clock_drive_in};
            end
            PCM_USART_SYNC_SLAVE:
            begin
                // clock comes in; pin keeps port drive, software sets it input
            end
            PCM_USART_OFF:
            begin
                drive_nxt[`PCM_BIT_TX] = port_drive[`PCM_BIT_TX];
            end
        endcase
        // sync data owns bit 7 only while sending, master or slave alike
        if (usart_mode_in[1] && usart_sync_data_sending_in)
        begin
            drive_nxt[`PCM_BIT_RX] = '{oe: 1'b1, val: usart_sync_data_drive_in};
        end
    end

    // pin drive registered so pads never see decode glitches
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            pin_out <= 8'h00;
            pin_oe_out <= 8'h00; // every pin an input at reset
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                pin_out[i] <= drive_nxt[i].val;
                pin_oe_out[i] <= drive_nxt[i].oe;
            end
        end
    end

    // =====================================================================
    // peripheral input routing
    // =====================================================================

    // pin levels back to the serial unit
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            spi_sck_sense_out <= 1'b0;
            spi_sdi_sense_out <= 1'b0;
            i2c_scl_sense_out <= 1'b1;
            i2c_sda_sense_out <= 1'b1;
            pin_smbus_levels_out <= 2'h0;
        end
        else
        begin
            spi_sck_sense_out <= pin_in[`PCM_BIT_SCK];
            spi_sdi_sense_out <= pin_in[`PCM_BIT_SDI];
            i2c_scl_sense_out <= pin_in[`PCM_BIT_SCK];
            i2c_sda_sense_out <= pin_in[`PCM_BIT_SDI];
            // pad threshold select only matters while i2c owns the pins
            pin_smbus_levels_out <= {2{ssu_i2c & ssu_smbus_levels_in}};
        end
    end

    // pin levels back to the usart
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            usart_rx_sense_out <= 1'b1;
            usart_sync_clock_sense_out <= 1'b0;
            usart_sync_data_sense_out <= 1'b0;
        end
        else
        begin
            usart_rx_sense_out <= pin_in[`PCM_BIT_RX];
            usart_sync_clock_sense_out <= pin_in[`PCM_BIT_TX];
            usart_sync_data_sense_out <= pin_in[`PCM_BIT_RX];
        end
    end

    // capture/compare two follows its pin select
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            cc2_capture_out <= 1'b0;
            port_b_bit3_cc2_out <= 1'b0;
            port_b_bit3_cc2_en_out <= 1'b0;
        end
        else
        begin
            cc2_capture_out <= cc2_pin_select_in ? pin_in[`PCM_BIT_CC2]
                                                 : port_b_bit3_in;
            port_b_bit3_cc2_out <= cc2_drive_in;
            port_b_bit3_cc2_en_out <= ~cc2_pin_select_in & cc2_drive_en_in;
        end
    end

endmodule // pcm_port_c_upper_pin_mux

`default_nettype wire

// [design/pcm_consts.svh]
// register offsets, reset values and pin positions of the port c pin mux
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// apb byte offsets
`define PCM_OFF_PIN_STATE 8'h00
`define PCM_OFF_OUT_LATCH 8'h04
`define PCM_OFF_PIN_DIR 8'h08

// reset values: every pin an input, latch cleared
`define PCM_DIR_RESET 8'hff
`define PCM_LATCH_RESET 8'h00

// pin positions
`define PCM_BIT_CC2 1
`define PCM_BIT_SCK 3
`define PCM_BIT_SDI 4
`define PCM_BIT_SDO 5
`define PCM_BIT_TX 6
`define PCM_BIT_RX 7

`endif

// [design/pcm_pkg.sv]
// types shared by the port c pin mux
`default_nettype none
package pcm_pkg;

    // mode of the synchronous serial unit as seen by the pins
    typedef enum logic [1:0]
    {
        PCM_SSU_OFF = 2'h0,
        PCM_SSU_SPI = 2'h1,
        PCM_SSU_I2C = 2'h2
    } pcm_ssu_mode_t;

    // usart operating mode as seen by the pins
    typedef enum logic [1:0]
    {
        PCM_USART_OFF = 2'h0,
        PCM_USART_ASYNC = 2'h1,
        PCM_USART_SYNC_MASTER = 2'h2,
        PCM_USART_SYNC_SLAVE = 2'h3
    } pcm_usart_mode_t;

    // per-pin drive pair
    typedef struct packed
    {
        logic oe;
        logic val;
    } pcm_drive_t;

endpackage

`default_nettype wire

// [sim/pcm_port_c_sva.sv]
// assertions on the ports of the port c pin mux
`timescale 1ns/1ps
`default_nettype none
module pcm_port_c_sva
    import pcm_pkg::*;
(
    // clock, reset and peripheral controls
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire pcm_ssu_mode_t ssu_mode_in,
    input wire logic ssu_smbus_levels_in,
    input wire logic i2c_scl_drive_in,
    input wire logic i2c_sda_drive_in,
    input wire pcm_usart_mode_t usart_mode_in,
    input wire logic usart_tx_drive_in,
    input wire logic usart_sync_clock_drive_in,
    input wire logic usart_sync_data_drive_in,
    input wire logic usart_sync_data_sending_in,
    input wire logic cc2_pin_select_in,
    input wire logic cc2_drive_en_in,
    input wire logic [7:0] pin_in,
    // observed outputs
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_out,
    input wire logic [1:0] pin_smbus_levels_out,
    input wire logic i2c_scl_sense_out,
    input wire logic port_b_bit3_cc2_en_out
);
    // ==========================================
    // pin ownership, one edge after the cause
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // i2c lines only pull low or release, never drive high
    chk_scl_open_drain: assert property ((ssu_mode_in == PCM_SSU_I2C) |=>
        pin_oe_out[3] == !$past(i2c_scl_drive_in) && !pin_out[3])
        else $error("scl pin drive wrong");
    chk_sda_open_drain: assert property ((ssu_mode_in == PCM_SSU_I2C) |=>
        pin_oe_out[4] == !$past(i2c_sda_drive_in) && !pin_out[4])
        else $error("sda pin drive wrong");
    chk_scl_sense_route: assert property ((ssu_mode_in == PCM_SSU_I2C) |=>
        i2c_scl_sense_out == $past(pin_in[3]))
        else $error("scl sense not the pin level");
    chk_smbus_level_sel: assert property (1'b1 |=>
        pin_smbus_levels_out == {2{$past(ssu_mode_in == PCM_SSU_I2C && ssu_smbus_levels_in)}})
        else $error("input level select wrong");
    // usart overrides hold regardless of the direction bit
    chk_tx_override: assert property ((usart_mode_in == PCM_USART_ASYNC) |=>
        pin_oe_out[6] && pin_out[6] == $past(usart_tx_drive_in))
        else $error("transmit pin not driven");
    chk_sync_clock_out: assert property ((usart_mode_in == PCM_USART_SYNC_MASTER) |=>
        pin_oe_out[6] && pin_out[6] == $past(usart_sync_clock_drive_in))
        else $error("sync clock pin not driven");
    chk_sync_data_out: assert property (usart_mode_in[1] && usart_sync_data_sending_in
        |=> pin_oe_out[7] && pin_out[7] == $past(usart_sync_data_drive_in))
        else $error("sync data pin not driven");
    chk_cc2_alt_enable: assert property (1'b1 |=>
        port_b_bit3_cc2_en_out == $past(!cc2_pin_select_in && cc2_drive_en_in))
        else $error("alternate cc2 enable wrong");
endmodule // pcm_port_c_sva
`default_nettype wire

// [sim/pcm_pin_load.sv]
// external pin load seen by the port c pins
`timescale 1ns/1ps
`default_nettype none
module pcm_pin_load
(
    // design drive and external load
    input wire logic [7:0] drv_val_in,
    input wire logic [7:0] drv_oe_in,
    input wire logic [7:0] ext_val_in,
    input wire logic [7:0] ext_oe_in,
    // resolved level
    output logic [7:0] level_out
);
    // ==========================================
    // resolution: design, then load, else pull-up keeps a released line high
    assign level_out = (drv_oe_in & drv_val_in) | (~drv_oe_in & ext_oe_in & ext_val_in)
        | (~drv_oe_in & ~ext_oe_in);
endmodule // pcm_pin_load
`default_nettype wire

// [sim/test_port_c_upper_pin_mux.sv]
// testbench for the port c pin mux
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.svh"
module test_port_c_upper_pin_mux
    import pcm_pkg::*;
;
    // ==========================================
    // signals
    logic clk_in, reset_n_in, psel_in, penable_in, pwrite_in, ssu_smbus_levels_in, err;
    logic spi_sck_drive_in, spi_sdo_drive_in, i2c_scl_drive_in, i2c_sda_drive_in;
    logic usart_tx_drive_in, usart_sync_clock_drive_in, usart_sync_data_drive_in;
    logic usart_sync_data_sending_in, cc2_pin_select_in, cc2_drive_in, cc2_drive_en_in;
    logic port_b_bit3_in, pready_out, pslverr_out, spi_sck_sense_out, spi_sdi_sense_out;
    logic i2c_scl_sense_out, i2c_sda_sense_out, usart_rx_sense_out, usart_sync_clock_sense_out;
    logic usart_sync_data_sense_out, cc2_capture_out, port_b_bit3_cc2_out, port_b_bit3_cc2_en_out;
    logic [1:0] pin_smbus_levels_out;
    logic [7:0] paddr_in, pin_in, pin_out, pin_oe_out, ext_val, ext_oe;
    logic [31:0] pwdata_in, prdata_out, rd;
    pcm_ssu_mode_t ssu_mode_in;
    pcm_usart_mode_t usart_mode_in;
    int errors, n_compared, cyc;

    // design and pin load
    pcm_port_c_upper_pin_mux u_dut (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pin_in, .pin_out,
        .pin_oe_out, .ssu_mode_in, .ssu_smbus_levels_in, .spi_sck_drive_in, .spi_sdo_drive_in,
        .i2c_scl_drive_in, .i2c_sda_drive_in, .spi_sck_sense_out, .spi_sdi_sense_out,
        .i2c_scl_sense_out, .i2c_sda_sense_out, .pin_smbus_levels_out, .usart_mode_in,
        .usart_tx_drive_in, .usart_sync_clock_drive_in, .usart_sync_data_drive_in,
        .usart_sync_data_sending_in, .usart_rx_sense_out, .usart_sync_clock_sense_out,
        .usart_sync_data_sense_out, .cc2_pin_select_in, .cc2_drive_in, .cc2_drive_en_in,
        .port_b_bit3_in, .cc2_capture_out, .port_b_bit3_cc2_out, .port_b_bit3_cc2_en_out);
    pcm_pin_load u_load (.drv_val_in(pin_out), .drv_oe_in(pin_oe_out), .ext_val_in(ext_val),
        .ext_oe_in(ext_oe), .level_out(pin_in));

    // ==========================================
    // clock and hang guard
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    // ==========================================
    // tasks
    // apb transfer: held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1)
            @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // pin outputs are registered, so look just after the next edge
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        {reset_n_in, psel_in, penable_in, pwrite_in, ssu_smbus_levels_in, spi_sck_drive_in,
            spi_sdo_drive_in, i2c_scl_drive_in, i2c_sda_drive_in, usart_tx_drive_in,
            usart_sync_clock_drive_in, usart_sync_data_drive_in, usart_sync_data_sending_in,
            cc2_pin_select_in, cc2_drive_in, cc2_drive_en_in, port_b_bit3_in, paddr_in,
            pwdata_in, ext_val, ext_oe} = '0;
        ssu_mode_in = PCM_SSU_OFF;
        usart_mode_in = PCM_USART_OFF;
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        ext_val <= 8'h5a;
        ext_oe <= 8'hff;
        apb(1'b0, `PCM_OFF_PIN_DIR, 0);
        cmp(rd, 32'(`PCM_DIR_RESET));
        tick();
        cmp(32'({pready_out, pin_oe_out}), 32'h100);
        apb(1'b0, `PCM_OFF_PIN_STATE, 0);
        cmp(rd, 32'h5a);
        apb(1'b1, `PCM_OFF_OUT_LATCH, 32'ha5);
        apb(1'b1, `PCM_OFF_PIN_DIR, 32'h0);
        tick();
        cmp(32'({pin_oe_out, pin_out}), 32'hffa5);
        apb(1'b1, `PCM_OFF_PIN_STATE, 32'h3c);
        apb(1'b1, `PCM_OFF_PIN_DIR, 32'hff);
        apb(1'b0, `PCM_OFF_OUT_LATCH, 0);
        cmp(rd, 32'h3c);
        // i2c and async transmit take pins with every direction bit set
        ext_val <= 8'h18;
        ssu_mode_in <= PCM_SSU_I2C;
        ssu_smbus_levels_in <= 1'b1;
        i2c_sda_drive_in <= 1'b1;
        usart_mode_in <= PCM_USART_ASYNC;
        usart_tx_drive_in <= 1'b1;
        tick();
        cmp(32'(pin_oe_out[6:3]), 32'h9);
        cmp(32'({pin_out[6], pin_out[3], pin_smbus_levels_out}), 32'hb);
        tick();
        cmp(32'({usart_rx_sense_out, i2c_scl_sense_out}), 32'h0);
        cmp(32'(i2c_sda_sense_out), 32'h1);
        apb(1'b0, `PCM_OFF_PIN_DIR, 0);
        cmp(rd, 32'hff);
        // spi outputs beat the latch where the direction bit is clear
        ssu_mode_in <= PCM_SSU_SPI;
        usart_mode_in <= PCM_USART_OFF;
        apb(1'b1, `PCM_OFF_PIN_DIR, 32'h10);
        tick();
        cmp(32'({pin_oe_out[5:3], pin_out[5], pin_out[3]}), 32'h14);
        cmp(32'({spi_sdi_sense_out, spi_sck_sense_out}), 32'h3);
        // synchronous usart as master, then as slave
        @(posedge clk_in);
        ssu_mode_in <= PCM_SSU_OFF;
        usart_mode_in <= PCM_USART_SYNC_MASTER;
        usart_sync_clock_drive_in <= 1'b1;
        usart_sync_data_sending_in <= 1'b1;
        apb(1'b1, `PCM_OFF_PIN_DIR, 32'hff);
        tick();
        cmp(32'({pin_oe_out[7:6], pin_out[7:6]}), 32'hd);
        @(posedge clk_in);
        usart_mode_in <= PCM_USART_SYNC_SLAVE;
        usart_sync_data_sending_in <= 1'b0;
        ext_val <= 8'hc0;
        tick();
        tick();
        cmp(32'(pin_oe_out[7:6]), 32'h0);
        cmp(32'(usart_sync_clock_sense_out), 32'h1);
        cmp(32'(usart_sync_data_sense_out), 32'h1);
        // capture/compare two on bit 1, then moved to port b bit 3
        @(posedge clk_in);
        usart_mode_in <= PCM_USART_OFF;
        cc2_pin_select_in <= 1'b1;
        cc2_drive_en_in <= 1'b1;
        cc2_drive_in <= 1'b1;
        port_b_bit3_in <= 1'b1;
        apb(1'b1, `PCM_OFF_PIN_DIR, 32'hfd);
        tick();
        cmp(32'({pin_oe_out[1], pin_out[1], port_b_bit3_cc2_en_out}), 32'h6);
        @(posedge clk_in);
        cc2_pin_select_in <= 1'b0;
        tick();
        cmp(32'({pin_out[1], port_b_bit3_cc2_en_out}), 32'h1);
        cmp(32'({port_b_bit3_cc2_out, cc2_capture_out}), 32'h3);
        // unmapped word answers zero with an error flag
        apb(1'b0, 8'h0c, 0);
        cmp({err, rd[30:0]}, 32'h80000000);
        tally_and_finish();
    end
endmodule // test_port_c_upper_pin_mux

bind pcm_port_c_upper_pin_mux pcm_port_c_sva u_sva (.clk_in, .reset_n_in, .ssu_mode_in,
    .ssu_smbus_levels_in, .i2c_scl_drive_in, .i2c_sda_drive_in, .usart_mode_in,
    .usart_tx_drive_in, .usart_sync_clock_drive_in, .usart_sync_data_drive_in,
    .usart_sync_data_sending_in, .cc2_pin_select_in, .cc2_drive_en_in, .pin_in, .pin_out,
    .pin_oe_out, .pin_smbus_levels_out, .i2c_scl_sense_out, .port_b_bit3_cc2_en_out);
`default_nettype wire
